// >>> include/adrc_pkg.sv
package adrc_pkg;

  // Register byte offsets
  localparam logic [8:0] OFF_DRAM_CONTROL = 9'h100;
  localparam logic [8:0] OFF_BLOCK0_ADDR  = 9'h108;
  localparam logic [8:0] OFF_BLOCK0_MASK  = 9'h10C;
  localparam logic [8:0] OFF_BLOCK1_ADDR  = 9'h110;
  localparam logic [8:0] OFF_BLOCK1_MASK  = 9'h114;

  // Control register fields; the register sits in the upper halfword
  localparam int CTL_LANE_LSB     = 16;
  localparam int CTL_SYNC_MODE    = 15;
  localparam int CTL_NO_COL_MUX   = 13;
  localparam int CTL_STROBE_LSB   = 11;
  localparam int CTL_PRECH_LSB    = 9;
  localparam int CTL_INTERVAL_LSB = 0;
  localparam int INTERVAL_W       = 9;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hBFFF;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  // Block address/control fields
  localparam int BLK_BASE_LSB   = 18;
  localparam int BLK_REFRESH_EN = 15;
  localparam int BLK_CAS_LSB    = 12;
  localparam int BLK_RP_LSB     = 10;
  localparam int BLK_RCD        = 8;
  localparam logic [31:0] BLK_RESET = 32'h0000_0000;
  // Mask register: valid bit
  localparam int MASK_VALID = 0;

  // Timing counts: field value plus a base, in clocks
  localparam logic [2:0] REF_STROBE_BASE = 3'h2;
  localparam logic [2:0] REF_PRECH_BASE  = 3'h1;
  localparam logic [2:0] CAS_BASE        = 3'h1;
  localparam logic [2:0] RP_BASE         = 3'h1;
  localparam logic [2:0] RCD_BASE        = 3'h1;
  localparam logic [2:0] REF_CAS_LEAD    = 3'h1;
  localparam int INTERVAL_SHIFT = 4;

  typedef enum {
    ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_RCAS, ST_RRAS, ST_RPRE
  } adrc_state_e;

  // DRAM-facing pins
  typedef struct packed {
    logic [1:0]  rasN;
    logic [3:0]  casN;
    logic        dramWriteFlagN;
    logic [31:0] addr;
  } adrc_pins_s;

  // Memory access request from the local bus
  typedef struct packed {
    logic        req;
    logic        write;
    logic [3:0]  byteEn;
    logic [31:0] addr;
  } adrc_req_s;

endpackage

// >>> rtl/adrc_refresh_timer.sv
`timescale 1ns/1ps
module adrc_refresh_timer
  import adrc_pkg::*;
#(
  parameter int IW = INTERVAL_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clkEn,
  input  wire logic [IW-1:0] intervalCount,
  input  wire logic          reload,
  output logic               refreshPending
);

  localparam int CW = IW + INTERVAL_SHIFT;

  logic [CW-1:0] count_ff;

  if (IW < 1 || IW > 16) begin : gBadWidth
    $error("adrc_refresh_timer: interval width out of range");
  end

  // Counts (count+1)*16 clocks, then waits at zero until the refresh is done
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '1;
    end else if (clkEn) begin
      if (reload) begin
        count_ff <= {intervalCount, {INTERVAL_SHIFT{1'b1}}}; // RL6 RL18
      end else if (count_ff != '0) begin
        count_ff <= count_ff - CW'(1);
      end
    end
  end

  // Held until the controller reloads, so no request is lost
  assign refreshPending = (count_ff == '0); // RL6

endmodule

// >>> rtl/adrc_dram_ctrl.sv
// Notes on behaviour
// RL1: Control bit 15 selects DRAM mode; zero (asynchronous) after reset.
// RL2: Once synchronous, software cannot clear the mode; only reset does.
// RL3: Bit 13 low multiplexes column addresses; high drives them unmultiplexed.
// RL4: Refresh row strobe width from bits 12-11: 2 to 5 clocks.
// RL5: Precharge after refresh from bits 10-9: 1 to 4 clocks before access.
// RL6: Refresh requested every (count+1)*16 clocks, count in bits 8-0.
// RL7: Each block timed by its own registers; both blocks refresh together.
// RL8: Row and column strobes change only on falling clock edges.
// RL9: Controller terminates every DRAM access itself.
// RL10: Software must not make blocks overlap; no priority between hits. Here block 1 wins when both hit.
// RL11: Two row strobes, one per block; chip selects in synchronous mode. Here synchronous mode starts no access and holds both row strobes high.
// RL12: Four byte strobes, strobe 0 is most significant byte.
// RL13: Write signal asserted during write cycles, negated during reads.
// RL14: Registers at 0x100, 0x108, 0x10C, 0x110, 0x114 in both modes.
// RL15: External masters may reach these registers.
// RL16: Software writes zero to reserved control bit 14.
// RL17: A block is refreshed only when its refresh-enable bit 15 is set.
// RL18: Pending refresh waits for the access, runs first, reloads interval.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module adrc_dram_ctrl
  import adrc_pkg::*;
#(
  parameter int COL_SHIFT = 10
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic [8:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire adrc_req_s   memReq,
  output logic             memAck,
  output adrc_pins_s       dramPins,
  output logic             syncMode
);

  if (COL_SHIFT < 0 || COL_SHIFT > 31) begin : gBadShift
    $error("adrc_dram_ctrl: column shift out of range");
  end

  logic [15:0] dramControl_ff;
  logic [31:0] blockAddrCtrl_ff [2];
  logic [31:0] blockMask_ff [2];
  logic [31:0] regRdData_ff;
  adrc_state_e state_ff;
  adrc_state_e nxt_state;
  logic [2:0]  wait_ff;
  logic [2:0]  nxt_wait;
  adrc_req_s   acc_ff;
  logic        accBlock_ff;
  adrc_pins_s  pins_ff;
  adrc_pins_s  nxt_pins;
  logic [1:0]  blockHit;
  logic [1:0]  refreshEn;
  logic        anyRefreshEn;
  logic        refreshPending;
  logic        refreshDone;
  logic        accept;
  logic        hitBlock;
  logic [31:0] accCtl;

  // Address match against base and mask of one block
  function automatic logic hitTest(input logic [31:0] addr,
                                   input logic [31:0] ctl,
                                   input logic [31:0] mask);
    logic [31:BLK_BASE_LSB] diff;
    diff = (addr[31:BLK_BASE_LSB] ^ ctl[31:BLK_BASE_LSB]) & ~mask[31:BLK_BASE_LSB];
    hitTest = mask[MASK_VALID] && (diff == '0);
  endfunction

  // Two-bit field plus base gives a clock count
  function automatic logic [2:0] fieldLen(input logic [1:0] fld,
                                          input logic [2:0] base);
    fieldLen = {1'b0, fld} + base;
  endfunction

  // Register writes; every decode is origin blind so external masters reach them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dramControl_ff <= CTL_RESET; // RL1
    end else if (clkEn && regWr && regAddr == OFF_DRAM_CONTROL) begin // RL14 RL15
      dramControl_ff <= regWrData[CTL_LANE_LSB +: 16] & CTL_WRITE_MASK; // RL16
      // Mode bit only ever sets; leaving synchronous mode needs a reset
      dramControl_ff[CTL_SYNC_MODE] <= dramControl_ff[CTL_SYNC_MODE]
                                       | regWrData[CTL_LANE_LSB + CTL_SYNC_MODE]; // RL2
    end
  end

  // Per-block registers, one generate slice each
  for (genvar b = 0; b < 2; b++) begin : gBlock
    localparam logic [8:0] CTL_OFF  = b ? OFF_BLOCK1_ADDR : OFF_BLOCK0_ADDR;
    localparam logic [8:0] MASK_OFF = b ? OFF_BLOCK1_MASK : OFF_BLOCK0_MASK;

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        blockAddrCtrl_ff[b] <= BLK_RESET; // RL17
        blockMask_ff[b]     <= BLK_RESET;
      end else if (clkEn && regWr) begin
        if (regAddr == CTL_OFF) begin // RL14
          blockAddrCtrl_ff[b] <= regWrData;
        end
        if (regAddr == MASK_OFF) begin // RL14
          blockMask_ff[b] <= regWrData;
        end
      end
    end

    // Block 1 takes priority when both blocks hit; overlap is the programmer's problem
    assign blockHit[b]  = hitTest(memReq.addr, blockAddrCtrl_ff[b], blockMask_ff[b]); // RL10
    assign refreshEn[b] = blockAddrCtrl_ff[b][BLK_REFRESH_EN]; // RL17
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdData_ff <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData_ff <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          OFF_DRAM_CONTROL: regRdData_ff <= {dramControl_ff, 16'h0000}; // RL14
          OFF_BLOCK0_ADDR:  regRdData_ff <= blockAddrCtrl_ff[0];
          OFF_BLOCK0_MASK:  regRdData_ff <= blockMask_ff[0];
          OFF_BLOCK1_ADDR:  regRdData_ff <= blockAddrCtrl_ff[1];
          OFF_BLOCK1_MASK:  regRdData_ff <= blockMask_ff[1];
          default:          regRdData_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign regRdData = regRdData_ff;
  assign syncMode  = dramControl_ff[CTL_SYNC_MODE]; // RL1

  assign anyRefreshEn = |refreshEn;
  // Interval restarts after a refresh, and is held loaded while nothing wants one
  assign refreshDone = (state_ff == ST_RPRE && wait_ff == 3'h0) || !anyRefreshEn
                       || syncMode; // RL18

  adrc_refresh_timer #(
    .IW(INTERVAL_W)
  ) uTimer (
    .core_clk      (core_clk),
    .rst           (rst),
    .clkEn         (clkEn),
    .intervalCount (dramControl_ff[CTL_INTERVAL_LSB +: INTERVAL_W]),
    .reload        (refreshDone),
    .refreshPending(refreshPending)
  );

  // Start an access only when idle, asynchronous and no refresh is waiting
  assign hitBlock = blockHit[1];
  assign accept   = (state_ff == ST_IDLE) && !syncMode && memReq.req
                    && (|blockHit) && !refreshPending; // RL18
  assign accCtl   = blockAddrCtrl_ff[accBlock_ff]; // RL7

  // Access capture; the requester holds its request until acknowledged
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_ff      <= '0;
      accBlock_ff <= 1'b0;
    end else if (clkEn && accept) begin
      acc_ff      <= memReq;
      accBlock_ff <= hitBlock;
    end
  end

  // Sequencer: next state and phase length
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = (wait_ff == 3'h0) ? 3'h0 : wait_ff - 3'h1;
    case (state_ff)
      ST_IDLE: begin
        if (!syncMode && anyRefreshEn && refreshPending) begin // RL18 RL17
          nxt_state = ST_RCAS;
          nxt_wait  = REF_CAS_LEAD - 3'h1;
        end else if (accept) begin
          nxt_state = ST_ROW;
          nxt_wait  = (hitTest(memReq.addr, blockAddrCtrl_ff[1], blockMask_ff[1])
                       ? {2'b00, blockAddrCtrl_ff[1][BLK_RCD]}
                       : {2'b00, blockAddrCtrl_ff[0][BLK_RCD]}) + RCD_BASE - 3'h1; // RL7
        end
      end
      ST_ROW: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_COL;
          nxt_wait  = fieldLen(accCtl[BLK_CAS_LSB +: 2], CAS_BASE) - 3'h1; // RL7
        end
      end
      ST_COL: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_PRE;
          nxt_wait  = fieldLen(accCtl[BLK_RP_LSB +: 2], RP_BASE) - 3'h1;
        end
      end
      ST_PRE: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RCAS: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_RRAS;
          nxt_wait  = fieldLen(dramControl_ff[CTL_STROBE_LSB +: 2],
                               REF_STROBE_BASE) - 3'h1; // RL4
        end
      end
      ST_RRAS: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_RPRE;
          nxt_wait  = fieldLen(dramControl_ff[CTL_PRECH_LSB +: 2],
                               REF_PRECH_BASE) - 3'h1; // RL5
        end
      end
      ST_RPRE: begin
        if (wait_ff == 3'h0) begin
          nxt_state = ST_IDLE; // RL5
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_wait  = 3'h0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      wait_ff  <= 3'h0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
    end
  end

  // Termination comes from here, never from an outside acknowledge
  assign memAck = (state_ff == ST_COL) && (wait_ff == 3'h0); // RL9

  // Pin values for the current phase
  always_comb begin
    nxt_pins      = '0;
    nxt_pins.rasN = 2'b11;
    nxt_pins.casN = 4'hF;
    nxt_pins.dramWriteFlagN = 1'b1;
    nxt_pins.addr = acc_ff.addr;
    case (state_ff)
      ST_ROW: begin
        nxt_pins.rasN[accBlock_ff] = 1'b0; // RL11
        nxt_pins.dramWriteFlagN    = !acc_ff.write; // RL13
      end
      ST_COL: begin
        nxt_pins.rasN[accBlock_ff] = 1'b0; // RL11
        // Lane 0 is the most significant byte
        nxt_pins.casN              = ~acc_ff.byteEn; // RL12
        nxt_pins.dramWriteFlagN    = !acc_ff.write; // RL13
        // Without the shift, external logic has to do the column muxing
        if (!dramControl_ff[CTL_NO_COL_MUX]) begin
          nxt_pins.addr = acc_ff.addr >> COL_SHIFT; // RL3
        end
      end
      ST_RCAS: begin
        nxt_pins.casN = 4'h0;
      end
      ST_RRAS: begin
        nxt_pins.casN = 4'h0;
        nxt_pins.rasN = ~refreshEn; // RL4 RL7 RL17
      end
      default: begin
        nxt_pins.rasN = 2'b11;
      end
    endcase
  end

  // Strobes leave on the falling edge, half a clock after the phase change
  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      pins_ff      <= '0;
      pins_ff.rasN <= 2'b11;
      pins_ff.casN <= 4'hF;
      pins_ff.dramWriteFlagN <= 1'b1;
    end else if (clkEn) begin
      pins_ff <= nxt_pins; // RL8
    end
  end

  assign dramPins = pins_ff;

endmodule

// >>> tb/adrc_assertions.sv
`timescale 1ns/1ps
module adrc_checker
  import adrc_pkg::*;
#(
  parameter int COL_SHIFT = 10
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic [8:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input wire adrc_req_s   memReq,
  input wire logic        memAck,
  input wire adrc_pins_s  dramPins,
  input wire logic        syncMode
);
  logic       noMux_ff;
  logic       modeWr_ff;
  logic [1:0] refEn_ff;
  logic [5:0] strobePos_ff;
  logic       wrTaken;
  assign wrTaken = regWr && clkEn;
  // Shadow only the fields the properties depend on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {noMux_ff, modeWr_ff, refEn_ff} <= '0;
    end else begin
      modeWr_ff <= wrTaken && regAddr == OFF_DRAM_CONTROL && regWrData[31];
      if (wrTaken && regAddr == OFF_DRAM_CONTROL) noMux_ff <= regWrData[29];
      if (wrTaken && regAddr == OFF_BLOCK0_ADDR) refEn_ff[0] <= regWrData[15];
      if (wrTaken && regAddr == OFF_BLOCK1_ADDR) refEn_ff[1] <= regWrData[15];
    end
  end
  // Strobes seen at a rising edge must survive to the next falling edge
  always_ff @(posedge core_clk) begin
    strobePos_ff <= {dramPins.rasN, dramPins.casN};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_mode_set; $rose(syncMode) |-> modeWr_ff; endproperty
  property p_mode_keep; syncMode |=> syncMode; endproperty
  property p_col_addr;
    memAck |-> dramPins.addr == (noMux_ff ? memReq.addr : memReq.addr >> COL_SHIFT);
  endproperty
  property p_strobe_neg;
    @(negedge core_clk) {dramPins.rasN, dramPins.casN} == strobePos_ff;
  endproperty
  property p_ack_row; memAck |-> !(&dramPins.rasN); endproperty
  property p_byte_lane; memAck |-> dramPins.casN == ~memReq.byteEn; endproperty
  property p_wr_flag; memAck |-> dramPins.dramWriteFlagN == !memReq.write; endproperty
  property p_ctl_read;
    regRd && clkEn && regAddr == OFF_DRAM_CONTROL |=> regRdData[15:0] == 16'h0 && !regRdData[30];
  endproperty
  property p_ref_enable; dramPins.casN == 4'h0 && &dramPins.rasN |-> |refEn_ff; endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode set without write");
  a_mode_keep: assert property (p_mode_keep) else $error("sync mode lost");
  a_col_addr: assert property (p_col_addr) else $error("column address wrong");
  a_strobe_neg: assert property (p_strobe_neg) else $error("strobe moved on rise");
  a_ack_row: assert property (p_ack_row) else $error("ack without row strobe");
  a_byte_lane: assert property (p_byte_lane) else $error("byte strobes wrong");
  a_wr_flag: assert property (p_wr_flag) else $error("write flag wrong");
  a_ctl_read: assert property (p_ctl_read) else $error("control read bits wrong");
  a_ref_enable: assert property (p_ref_enable) else $error("refresh while disabled");
  c_ack: cover property (memAck);
  c_refresh: cover property (dramPins.casN == 4'h0 && &dramPins.rasN);
  c_sync: cover property ($rose(syncMode));
endmodule
bind adrc_dram_ctrl adrc_checker #(.COL_SHIFT(COL_SHIFT)) u_chk (
  .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .memReq(memReq), .memAck(memAck), .dramPins(dramPins), .syncMode(syncMode)
);

// >>> tb/adrc_dram_model.sv
`timescale 1ns/1ps
module adrc_dram_model
  import adrc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire adrc_pins_s pins,
  output logic [7:0]      refCnt0,
  output logic [7:0]      refCnt1,
  output logic [7:0]      rasWidth,
  output logic [15:0]     period,
  output logic [7:0]      gap,
  output logic            lastBlk
);
  logic        inRef;
  logic        rasIdle;
  logic [7:0]  run0;
  logic [7:0]  run1;
  logic [7:0]  hiCnt;
  logic [15:0] cyc;
  logic [15:0] lastStart;
  // CAS low with both RAS high opens a refresh; all CAS high closes it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {inRef, run0, run1, hiCnt, cyc, lastStart} <= '0;
      {refCnt0, refCnt1, rasWidth, period, gap, lastBlk} <= '0;
      rasIdle <= 1'b1;
    end else begin
      cyc <= cyc + 16'h1;
      rasIdle <= &pins.rasN;
      if (!inRef && pins.casN == 4'h0 && &pins.rasN) begin
        inRef <= 1'b1;
        period <= cyc - lastStart;
        lastStart <= cyc;
        run0 <= 8'h0;
        run1 <= 8'h0;
      end else if (inRef && pins.casN == 4'hF) begin
        inRef <= 1'b0;
        hiCnt <= 8'h1;
        refCnt0 <= refCnt0 + {7'h0, run0 != 8'h0};
        refCnt1 <= refCnt1 + {7'h0, run1 != 8'h0};
        rasWidth <= run0 | run1;
      end else if (inRef) begin
        run0 <= run0 + {7'h0, !pins.rasN[0]};
        run1 <= run1 + {7'h0, !pins.rasN[1]};
      end else begin
        // Each clock of RAS high holds exactly one rising edge
        hiCnt <= hiCnt + 8'h1;
        if (rasIdle && !(&pins.rasN)) begin
          gap <= hiCnt;
          lastBlk <= pins.rasN[0];
        end
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import adrc_pkg::*;
;
  logic        core_clk;
  logic        rst;
  logic [8:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  adrc_req_s   memReq;
  logic        memAck;
  adrc_pins_s  dramPins;
  logic        syncMode;
  logic [7:0]  refCnt0;
  logic [7:0]  refCnt1;
  logic [7:0]  rasWidth;
  logic [15:0] period;
  logic [7:0]  gap;
  logic        lastBlk;
  logic        ack;
  logic        clkEn;
  int          errTotal = 0;
  int          nChecks = 0;
  int          cycles = 0;
  adrc_dram_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .memReq(memReq), .memAck(memAck), .dramPins(dramPins), .syncMode(syncMode)
  );
  adrc_dram_model u_mem (
    .core_clk(core_clk), .rst(rst), .pins(dramPins), .refCnt0(refCnt0),
    .refCnt1(refCnt1), .rasWidth(rasWidth), .period(period), .gap(gap), .lastBlk(lastBlk)
  );
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 check(nm, regRdData, e);
  endtask
  // Request stays up until the edge that closes the acknowledge cycle
  task automatic mem(input logic [31:0] a, input logic w, input logic [3:0] be);
    @(posedge core_clk);
    memReq <= '{1'b1, w, be, a};
    ack = 1'b0;
    for (int k = 0; k < 40 && !ack; k++) begin
      @(negedge core_clk);
      ack = memAck;
    end
    @(posedge core_clk);
    memReq.req <= 1'b0;
  endtask
  task automatic wait_ref(input int n);
    logic [7:0] c0;
    repeat (n) begin
      c0 = refCnt0;
      for (int k = 0; k < 100 && refCnt0 == c0; k++) @(posedge core_clk);
    end
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    logic [8:0] offs [4] = '{OFF_BLOCK0_ADDR, OFF_BLOCK0_MASK, OFF_BLOCK1_ADDR, OFF_BLOCK1_MASK};
    rd(OFF_DRAM_CONTROL, 32'h0, "ctl reset");
    rd(OFF_BLOCK1_ADDR, 32'h0, "blk1 reset");
    wr(OFF_DRAM_CONTROL, 32'h7FFF_FFFF);
    rd(OFF_DRAM_CONTROL, 32'h3FFF_0000, "ctl rw");
    foreach (offs[i]) begin
      wr(offs[i], 32'hC3C3_0001 ^ i);
      rd(offs[i], 32'hC3C3_0001 ^ i, "blk reg");
    end
    wr(9'h104, 32'hFFFF_FFFF);
    rd(9'h104, 32'h0, "unmapped");
    // A write while the enable is low must leave the register untouched
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(OFF_BLOCK0_ADDR, 32'h0);
    clkEn <= 1'b1;
    rd(OFF_BLOCK0_ADDR, 32'hC3C3_0001, "frozen");
    $display("t_regs done");
  endtask
  task automatic t_access();
    wr(OFF_BLOCK0_ADDR, 32'h0);
    wr(OFF_BLOCK0_MASK, 32'h1);
    wr(OFF_BLOCK1_ADDR, 32'h0004_3500);
    wr(OFF_BLOCK1_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_DRAM_CONTROL, {2'h0, i[1], 29'h0});
      mem({13'h0, i[0], 18'h1234}, i[0], 4'h5 ^ i[3:0]);
      check("ack", ack, 1'b1);
      check("block", lastBlk, i[0]);
    end
    $display("t_access done");
  endtask
  task automatic t_refresh();
    logic [7:0] s1;
    wr(OFF_BLOCK0_ADDR, 32'h0000_8000);
    for (int r = 0; r < 4; r++) begin
      wr(OFF_DRAM_CONTROL, {3'h0, r[1:0], 2'h0, 9'h1, 16'h0});
      wait_ref(2);
      check("ras width", rasWidth, r + 2);
      check("period", period >= 16'd32 && period <= 16'd44, 1'b1);
    end
    wr(OFF_BLOCK1_ADDR, 32'h0004_B500);
    wait_ref(1);
    s1 = refCnt1;
    wait_ref(2);
    check("both blocks", refCnt1 - s1, 8'h2);
    // Disable right after a refresh closes, so none is cut in flight
    wait_ref(1);
    wr(OFF_BLOCK0_ADDR, 32'h0);
    wr(OFF_BLOCK1_ADDR, 32'h0004_3500);
    repeat (20) @(posedge core_clk);
    s1 = refCnt0;
    repeat (150) @(posedge core_clk);
    check("no refresh", refCnt0, s1);
    $display("t_refresh done");
  endtask
  task automatic t_prech();
    wr(OFF_DRAM_CONTROL, {3'h0, 2'h0, 2'h3, 9'h1, 16'h0});
    wr(OFF_BLOCK0_ADDR, 32'h0000_8000);
    for (int k = 0; k < 100 && !(dramPins.casN == 4'h0 && &dramPins.rasN); k++) begin
      @(posedge core_clk);
    end
    mem(32'h0000_0040, 1'b0, 4'hF);
    check("ack after refresh", ack, 1'b1);
    check("precharge", gap >= 8'd4, 1'b1);
    $display("t_prech done");
  endtask
  task automatic t_sync();
    wr(OFF_DRAM_CONTROL, 32'h8000_0000);
    check("mode on", syncMode, 1'b1);
    wr(OFF_DRAM_CONTROL, 32'h0);
    check("mode kept", syncMode, 1'b1);
    mem(32'h0000_0100, 1'b1, 4'hF);
    check("sync ignored", ack, 1'b0);
    reset_dut();
    check("mode reset", syncMode, 1'b0);
    $display("t_sync done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well beyond the thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errTotal++;
      end_sim();
    end
  end
  initial begin
    {rst, regAddr, regWrData, regWr, regRd} = {1'b1, 9'h0, 32'h0, 2'h0};
    memReq = '0;
    clkEn = 1'b1;
    reset_dut();
    t_regs();
    t_access();
    t_refresh();
    t_prech();
    t_sync();
    end_sim();
  end
endmodule
